// >>> rtl/bioprt_pkg.sv
/*
 * Constants for the three-port bidirectional I/O block with tone output.
 * Assumes an 8-bit data memory bus of the host core reaches the ports.
 */
package bioprt_pkg;
    // Data memory locations of the port latches and direction registers
    localparam logic [7:0] ADDR_PORT_A_DATA = 8'h12;
    localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h13;
    localparam logic [7:0] ADDR_PORT_B_DATA = 8'h14;
    localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h15;
    localparam logic [7:0] ADDR_PORT_C_DATA = 8'h16;
    localparam logic [7:0] ADDR_PORT_C_DIRECTION = 8'h17;
    // Implemented line counts
    localparam int WIDTH_A = 8;
    localparam int WIDTH_B = 3;
    localparam int WIDTH_C = 2;
    // Values after reset: every line an input, every latch high
    localparam logic [7:0] RESET_PORT_A = 8'hff;
    localparam logic [2:0] RESET_PORT_B = 3'h7;
    localparam logic [1:0] RESET_PORT_C = 2'h3;
    // Tone generator: overflow range and counter reset value
    localparam logic [8:0] TONE_RANGE = 9'h100;
    localparam logic [7:0] RESET_TONE_COUNT = 8'h00;
    // Read-modify-write operation codes
    typedef enum logic [1:0] {
        BIOPRT_OP_NONE = 2'b00,
        BIOPRT_OP_SET = 2'b01,
        BIOPRT_OP_CLR = 2'b10,
        BIOPRT_OP_CPL = 2'b11
    } bioprt_op_t;
endpackage

// >>> rtl/bioprt_tone_if.sv
/*
 * Carrier between the port block and its tone generator.
 * Assumes one clock domain.
 */
`timescale 1ns/10ps
interface bioprt_tone_if;
    logic tick;
    logic [7:0] preload;
    logic tone;
    modport gen (input tick, input preload, output tone);
    modport user (output tick, output preload, input tone);
endinterface

// >>> rtl/bioprt_tone.sv
/*
 * Tone generator: an 8-bit up-counter reloaded from the preload on
 * overflow; each overflow toggles the tone, so the tone runs at
 * tick rate / (2 x (256 - preload)).
 * Assumes tick is a one-cycle enable from the timer input clock.
 */
`timescale 1ns/10ps
module bioprt_tone (
    input wire logic i_clk,
    input wire logic i_reset,
    bioprt_tone_if.gen tif
);
    logic [7:0] count;
    logic tone;

    // Count up and reload on overflow (R17)
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count <= bioprt_pkg::RESET_TONE_COUNT;
        end else if (tif.tick) begin
            if (count == 8'hff) begin
                count <= tif.preload; // R17
            end else begin
                count <= count + 8'h01;
            end
        end
    end

    // Toggle the tone on each overflow
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tone <= 1'b0;
        end else if (tif.tick && count == 8'hff) begin
            tone <= ~tone; // R17
        end
    end

    assign tif.tone = tone;
endmodule

// >>> rtl/bioprt_top.sv
/*
 * Three bidirectional ports A (8 lines), B (3) and C (2) with
 * per-port direction registers, live pad read-back, bit operations,
 * port A wake-up, a global pull-high option and a tone output pair.
 * Assumes pad inputs are synchronous to I_CLK and that the core
 * presents one access per cycle on the data memory port.
 */
// Overview of operation
// (R1) Three ports A, B, C, 13 lines, latches at 12H, 14H, 16H.
// (R2) Direction registers for A, B, C at 13H, 15H, 17H.
// (R3) Direction 1 makes an input; 0 makes a push-pull output.
// (R4) Reads return pad level for inputs, latch value for outputs.
// (R5) Inputs are not latched; pad sampled in the reading cycle.
// (R6) Written output data holds until the latch is written again.
// (R7) Bit set, clear and complement read, modify and write back.
// (R8) Missing upper bits of B and C read zero, ignore writes.
// (R9) With wake-up enabled, any port A line can wake the halted device; the code wakes on input lines only.
// (R10) One pull-high option enables pull-ups on all lines or none.
// (R11) After reset every line is an input.
// (R12) Tone option: B lines 0 and 1 as outputs drive tone and complement.
// (R13) Tone option: B bit 0 latch gates both tone pins, 0 forces low.
// (R14) Tone option: B line 0 or 1 as input keeps input behaviour.
// (R15) C lines 0 and 1 share pins with interrupt and timer event inputs.
// (R16) Software should make unused lines outputs to save power.
// (R17) Tone frequency is timer clock over 2 x (256 - preload).
// (R18) Direction writes change pad drivers on the next clock edge.
`timescale 1ns/10ps
module bioprt_top (
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Build-time options
    input wire logic I_PULL_HIGH_OPTION,
    input wire logic I_TONE_OPTION,
    input wire logic I_WAKE_OPTION,
    // Data memory port of the core
    input wire logic [7:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [1:0] I_BIT_OP,
    input wire logic [2:0] I_BIT_SEL,
    input wire logic [7:0] I_WDATA,
    output logic [7:0] O_RDATA,
    output logic O_HIT,
    // Timer tone source
    input wire logic I_TONE_TICK,
    input wire logic [7:0] I_TONE_PRELOAD,
    // Halt state and wake request
    input wire logic I_HALTED,
    output logic O_WAKE,
    // Pads
    input wire logic [7:0] I_PORT_A_PAD,
    output logic [7:0] O_PORT_A_PAD,
    output logic [7:0] O_PORT_A_OE,
    input wire logic [2:0] I_PORT_B_PAD,
    output logic [2:0] O_PORT_B_PAD,
    output logic [2:0] O_PORT_B_OE,
    input wire logic [1:0] I_PORT_C_PAD,
    output logic [1:0] O_PORT_C_PAD,
    output logic [1:0] O_PORT_C_OE,
    output logic O_PULL_UP_EN,
    // Shared-pin inputs towards interrupt and timer
    output logic O_EXT_INT_IN,
    output logic O_TIMER_EVENT_PIN
);
    logic [7:0] port_a_data;
    logic [7:0] port_a_direction;
    logic [2:0] port_b_data;
    logic [2:0] port_b_direction;
    logic [1:0] port_c_data;
    logic [1:0] port_c_direction;
    logic [7:0] read_value;
    logic [7:0] next_write;
    logic [7:0] prev_pad_a;
    logic tone_out_pair;
    logic [1:0] tone_pin;
    bioprt_pkg::bioprt_op_t op;
    bioprt_tone_if tif ();

    // Mixed read: pad for inputs, latch for outputs
    function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir,
                                             input logic [7:0] pad);
        port_view = (dir & pad) | (~dir & latch); // R4 R5
    endfunction

    // Bit operation on a whole byte
    function automatic logic [7:0] bit_modify(input logic [7:0] value, input logic [1:0] code,
                                              input logic [2:0] sel, input logic [7:0] wdata);
        logic [7:0] mask;
        mask = 8'h01 << sel;
        case (code)
            2'b01: bit_modify = value | mask;
            2'b10: bit_modify = value & ~mask;
            2'b11: bit_modify = ~value;
            default: bit_modify = wdata;
        endcase
    endfunction

    assign op = bioprt_pkg::bioprt_op_t'(I_BIT_OP);

    // Tone generator from timer overflow
    assign tif.tick = I_TONE_TICK;
    assign tif.preload = I_TONE_PRELOAD;
    bioprt_tone u_tone (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .tif(tif)
    );
    assign tone_out_pair = tif.tone;

    // Read multiplexer; absent bits read zero
    always_comb begin
        if (I_ADDR == bioprt_pkg::ADDR_PORT_A_DATA) begin
            read_value = port_view(port_a_data, port_a_direction, I_PORT_A_PAD); // R4
        end else if (I_ADDR == bioprt_pkg::ADDR_PORT_A_DIRECTION) begin
            read_value = port_a_direction;
        end else if (I_ADDR == bioprt_pkg::ADDR_PORT_B_DATA) begin
            read_value = port_view({5'h00, port_b_data}, {5'h00, port_b_direction},
                                   {5'h00, I_PORT_B_PAD}); // R8
        end else if (I_ADDR == bioprt_pkg::ADDR_PORT_B_DIRECTION) begin
            read_value = {5'h00, port_b_direction}; // R8
        end else if (I_ADDR == bioprt_pkg::ADDR_PORT_C_DATA) begin
            read_value = port_view({6'h00, port_c_data}, {6'h00, port_c_direction},
                                   {6'h00, I_PORT_C_PAD}); // R8
        end else if (I_ADDR == bioprt_pkg::ADDR_PORT_C_DIRECTION) begin
            read_value = {6'h00, port_c_direction}; // R8
        end else begin
            read_value = 8'h00;
        end
    end

    // Value to write: plain data or read-modify-write result
    assign next_write = bit_modify(read_value, op, I_BIT_SEL, I_WDATA); // R7

    // Address hit indicator for the core
    assign O_HIT = (I_ADDR >= bioprt_pkg::ADDR_PORT_A_DATA) &&
                   (I_ADDR <= bioprt_pkg::ADDR_PORT_C_DIRECTION); // R1 R2

    // Registered read data; complement and bit results also shown here
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_RDATA <= 8'h00;
        end else if (I_RD) begin
            if (!O_HIT) begin
                O_RDATA <= 8'h00; // Unmapped reads stay zero even with a bit operation
            end else if (op == bioprt_pkg::BIOPRT_OP_NONE) begin
                O_RDATA <= read_value; // R5
            end else begin
                O_RDATA <= next_write; // R7
            end
        end
    end

    // Port A registers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            port_a_data <= bioprt_pkg::RESET_PORT_A;
            port_a_direction <= bioprt_pkg::RESET_PORT_A; // R11
        end else if (I_WR) begin
            if (I_ADDR == bioprt_pkg::ADDR_PORT_A_DATA) begin
                port_a_data <= next_write; // R1 R6 R7
            end else if (I_ADDR == bioprt_pkg::ADDR_PORT_A_DIRECTION) begin
                port_a_direction <= next_write; // R2 R18
            end
        end
    end

    // Port B registers; upper bits do not exist
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            port_b_data <= bioprt_pkg::RESET_PORT_B;
            port_b_direction <= bioprt_pkg::RESET_PORT_B; // R11
        end else if (I_WR) begin
            if (I_ADDR == bioprt_pkg::ADDR_PORT_B_DATA) begin
                port_b_data <= next_write[2:0]; // R6 R8
            end else if (I_ADDR == bioprt_pkg::ADDR_PORT_B_DIRECTION) begin
                port_b_direction <= next_write[2:0]; // R8 R18
            end
        end
    end

    // Port C registers; upper bits do not exist
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            port_c_data <= bioprt_pkg::RESET_PORT_C;
            port_c_direction <= bioprt_pkg::RESET_PORT_C; // R11
        end else if (I_WR) begin
            if (I_ADDR == bioprt_pkg::ADDR_PORT_C_DATA) begin
                port_c_data <= next_write[1:0]; // R6 R8
            end else if (I_ADDR == bioprt_pkg::ADDR_PORT_C_DIRECTION) begin
                port_c_direction <= next_write[1:0]; // R8 R18
            end
        end
    end

    // Tone pins: gated by bit 0 latch, complement on line one
    assign tone_pin[0] = port_b_data[0] & tone_out_pair; // R12 R13
    assign tone_pin[1] = port_b_data[0] & ~tone_out_pair; // R12 R13

    // Pad drivers: direction 0 drives push-pull
    always_comb begin
        O_PORT_A_OE = ~port_a_direction; // R3
        O_PORT_A_PAD = port_a_data;
        O_PORT_B_OE = ~port_b_direction; // R3 R14
        O_PORT_B_PAD = port_b_data;
        if (I_TONE_OPTION) begin
            O_PORT_B_PAD[1:0] = tone_pin; // R12
        end
        O_PORT_C_OE = ~port_c_direction; // R3
        O_PORT_C_PAD = port_c_data;
    end

    // One global pull-up enable
    assign O_PULL_UP_EN = I_PULL_HIGH_OPTION; // R10

    // Shared pins feed the interrupt and timer event inputs
    assign O_EXT_INT_IN = I_PORT_C_PAD[0]; // R15
    assign O_TIMER_EVENT_PIN = I_PORT_C_PAD[1]; // R15

    // Previous port A pad level for change detection; reset follows the pads
    // so that pulled-up lines do not look like an edge right after reset
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            prev_pad_a <= I_PORT_A_PAD;
        end else begin
            prev_pad_a <= I_PORT_A_PAD;
        end
    end

    // Wake request on any port A input line change while halted
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_WAKE <= 1'b0;
        end else begin
            O_WAKE <= I_WAKE_OPTION && I_HALTED &&
                      (|((I_PORT_A_PAD ^ prev_pad_a) & port_a_direction)); // R9
        end
    end
endmodule

// >>> testbench/bioprt_chk.sv
/*
 * Port-level checks for the three-port I/O block.
 * Assumes it is bound into bioprt_top and sees only its ports.
 */
`timescale 1ns/10ps
module bioprt_chk (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_PULL_HIGH_OPTION,
    input wire logic I_TONE_OPTION,
    input wire logic I_WAKE_OPTION,
    input wire logic [7:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [1:0] I_BIT_OP,
    input wire logic [7:0] I_WDATA,
    input wire logic [7:0] O_RDATA,
    input wire logic O_HIT,
    input wire logic I_HALTED,
    input wire logic O_WAKE,
    input wire logic [7:0] I_PORT_A_PAD,
    input wire logic [7:0] O_PORT_A_PAD,
    input wire logic [7:0] O_PORT_A_OE,
    input wire logic [2:0] O_PORT_B_PAD,
    input wire logic [2:0] O_PORT_B_OE,
    input wire logic [1:0] O_PORT_C_OE,
    input wire logic [1:0] I_PORT_C_PAD,
    input wire logic O_PULL_UP_EN,
    input wire logic O_EXT_INT_IN,
    input wire logic O_TIMER_EVENT_PIN
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // Decode, read-back and direction relations
    a_hit_decode: assert property (O_HIT == (I_ADDR inside {[8'h12:8'h17]}))
        else $error("hit flag disagrees with address");
    a_unmapped_zero: assert property (I_RD && !(I_ADDR inside {[8'h12:8'h17]}) |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_dir_write: assert property (I_WR && I_ADDR == 8'h13 && I_BIT_OP == 2'b00
        |=> O_PORT_A_OE == ~$past(I_WDATA))
        else $error("direction write not seen on drivers");
    a_read_mix: assert property (I_RD && !I_WR && I_ADDR == 8'h12 && I_BIT_OP == 2'b00
        |=> O_RDATA == (($past(I_PORT_A_PAD) & ~$past(O_PORT_A_OE))
        | ($past(O_PORT_A_PAD) & $past(O_PORT_A_OE))))
        else $error("read-back mixes pad and latch wrongly");
    a_upper_zero: assert property (I_RD && I_ADDR[7:1] == 7'h0a |=> O_RDATA[7:3] == 5'h00)
        else $error("absent bits read non-zero");
    a_latch_hold: assert property (!(I_WR && I_ADDR == 8'h12) |=> $stable(O_PORT_A_PAD))
        else $error("output latch moved without a write");
    a_reset_inputs: assert property (disable iff (1'b0) I_RESET |=> O_PORT_A_OE == 8'h00
        && O_PORT_B_OE == 3'h0 && O_PORT_C_OE == 2'h0 && !O_WAKE)
        else $error("reset left a line driving");
    // Tone pair, wake-up, shared pins and pull-up enable
    a_tone_pair: assert property (I_TONE_OPTION && O_PORT_B_OE[1:0] == 2'b11
        |-> (O_PORT_B_PAD[0] ^ O_PORT_B_PAD[1]) || O_PORT_B_PAD[1:0] == 2'b00)
        else $error("tone pins neither complementary nor gated low");
    a_wake_edge: assert property (I_WAKE_OPTION && I_HALTED && O_PORT_A_OE == 8'h00
        && $stable(O_PORT_A_OE) && $changed(I_PORT_A_PAD) |-> ##[1:2] O_WAKE)
        else $error("input change while halted gave no wake");
    a_pins_shared: assert property (O_EXT_INT_IN == I_PORT_C_PAD[0]
        && O_TIMER_EVENT_PIN == I_PORT_C_PAD[1] && O_PULL_UP_EN == I_PULL_HIGH_OPTION)
        else $error("shared pin or pull-up enable mismatch");
endmodule
bind bioprt_top bioprt_chk bioprt_chk_i (.*);

// >>> testbench/bioprt_pads.sv
/*
 * Board model of the 13 pads: device drive, board drive or pull-up.
 * Assumes lines packed as C[12:11], B[10:8], A[7:0].
 */
`timescale 1ns/10ps
module bioprt_pads (
    input wire logic i_clk,
    input wire logic i_pull,
    input wire logic [12:0] i_dout,
    input wire logic [12:0] i_oe,
    input wire logic [12:0] i_ext,
    input wire logic [12:0] i_ext_en,
    output logic [12:0] o_pad
);
    logic [12:0] wander = 13'h0aaa;
    // Floating lines without pull-up change every cycle
    always @(posedge i_clk) begin
        wander <= ~wander;
    end
    // Device drive wins, then board drive, then pull-up or float
    assign o_pad = (i_oe & i_dout) | (~i_oe & ((i_ext_en & i_ext)
        | (~i_ext_en & (i_pull ? 13'h1fff : wander))));
endmodule

// >>> testbench/tb_bioprt_top.sv
/*
 * Self-checking bench for bioprt_top through its data memory port.
 * Assumes the board model bioprt_pads and the bound checker.
 */
`timescale 1ns/10ps
module tb_bioprt_top;
    logic clk, rst, wr, rd, tick, halted, wake;
    logic [1:0] op;
    logic [2:0] sel;
    logic [7:0] addr, wd, rdata;
    logic [12:0] pad, dout, oe, ext, ext_en;
    int n_fail, cmp_count, n;
    logic [7:0] rst_exp [6] = '{8'hff, 8'hff, 8'h07, 8'h07, 8'h03, 8'h03};
    bioprt_top bioprt_top_i (.I_CLK(clk), .I_RESET(rst), .I_PULL_HIGH_OPTION(1'b1),
        .I_TONE_OPTION(1'b1), .I_WAKE_OPTION(1'b1), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_BIT_OP(op), .I_BIT_SEL(sel), .I_WDATA(wd), .O_RDATA(rdata), .O_HIT(),
        .I_TONE_TICK(tick), .I_TONE_PRELOAD(8'hfc), .I_HALTED(halted), .O_WAKE(wake),
        .I_PORT_A_PAD(pad[7:0]), .O_PORT_A_PAD(dout[7:0]), .O_PORT_A_OE(oe[7:0]),
        .I_PORT_B_PAD(pad[10:8]), .O_PORT_B_PAD(dout[10:8]), .O_PORT_B_OE(oe[10:8]),
        .I_PORT_C_PAD(pad[12:11]), .O_PORT_C_PAD(dout[12:11]), .O_PORT_C_OE(oe[12:11]),
        .O_PULL_UP_EN(), .O_EXT_INT_IN(), .O_TIMER_EVENT_PIN());
    bioprt_pads bioprt_pads_i (.i_clk(clk), .i_pull(1'b1), .i_dout(dout), .i_oe(oe),
        .i_ext(ext), .i_ext_en(ext_en), .o_pad(pad));
    // One access: strobe for one edge, then release
    task automatic acc(input logic [7:0] a, input logic w, input logic r,
        input logic [1:0] o, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= r;
        op <= o;
        sel <= s;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        acc(a, 1'b0, 1'b1, 2'b00, 3'h0, 8'h00);
        #1;
        chk(rdata, exp);
    endtask
    // Cycles until tone line B0 changes level
    task automatic wait_toggle(output int cnt);
        logic v;
        v = dout[8];
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (dout[8] === v && cnt < 600);
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Watchdog
    initial begin
        #20000;
        n_fail++;
        print_verdict;
    end
    // Main sequence
    initial begin
        {rst, wr, rd, tick, halted} = 5'b10000;
        {addr, wd, op, sel, ext, ext_en} = '0;
        n_fail = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick <= 1'b1;
        for (int k = 0; k < 6; k++) rd_chk(8'h12 + 8'(k), rst_exp[k]);
        rd_chk(8'h18, 8'h00);
        acc(8'h17, 1'b1, 1'b0, 2'b00, 3'h0, 8'h00);
        ext <= 13'h0033;
        ext_en <= 13'h00ff;
        acc(8'h13, 1'b1, 1'b0, 2'b00, 3'h0, 8'hf0);
        acc(8'h12, 1'b1, 1'b0, 2'b00, 3'h0, 8'h5a);
        rd_chk(8'h12, 8'h3a);
        acc(8'h12, 1'b1, 1'b0, 2'b01, 3'h7, 8'h00);
        acc(8'h13, 1'b1, 1'b0, 2'b00, 3'h0, 8'h00);
        rd_chk(8'h12, 8'hba);
        acc(8'h12, 1'b1, 1'b0, 2'b10, 3'h1, 8'h00);
        acc(8'h12, 1'b0, 1'b1, 2'b11, 3'h0, 8'h00);
        #1 chk(rdata, 8'h47);
        rd_chk(8'h12, 8'hb8);
        acc(8'h15, 1'b1, 1'b0, 2'b00, 3'h0, 8'h00);
        acc(8'h14, 1'b1, 1'b0, 2'b00, 3'h0, 8'hfa);
        rd_chk(8'h14, 8'h02);
        chk({5'h00, dout[10:8]}, 8'h00);
        acc(8'h14, 1'b1, 1'b0, 2'b00, 3'h0, 8'h01);
        wait_toggle(n);
        wait_toggle(n);
        wait_toggle(n);
        chk(n[7:0], 8'h04);
        acc(8'h13, 1'b1, 1'b0, 2'b00, 3'h0, 8'hff);
        halted <= 1'b1;
        @(posedge clk);
        ext <= 13'h0032;
        n = 0;
        while (wake !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, wake}, 8'h01);
        print_verdict;
    end
endmodule
